/* include/gate_cfg_pkg.sv */
// Package for the soft-shutdown and delay configuration register block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
`default_nettype none
package gate_cfg_pkg;
  // Clock rate
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned CLOCK_PERIOD_NS = 1000000000 / CLOCK_HZ;
  // Frame layout
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned RW_POS = 23;
  localparam int unsigned ADDR_MSB = 22;
  localparam int unsigned ADDR_LSB = 18;
  localparam int unsigned DATA_MSB = 17;
  localparam int unsigned DATA_LSB = 8;
  localparam int unsigned CRC_MSB = 7;
  // Register address
  localparam logic [4:0] SOFT_SHUTDOWN_DELAY_CONFIG_ADDR = 5'h04;
  localparam logic [9:0] SOFT_SHUTDOWN_DELAY_CONFIG_RESET = 10'h024;
  // Field positions inside the ten data bits
  localparam int unsigned FAILSAFE_INT_SELECT_POS = 9;
  localparam int unsigned SEGMENT_DRIVE_DELAY_LSB = 6;
  localparam int unsigned SOFT_OFF_CURRENT_LSB = 3;
  localparam int unsigned SOFT_OFF_DURATION_LSB = 0;
  // Mask of fields that stay writable in normal mode
  localparam logic [9:0] ALWAYS_WRITABLE_MASK = 10'h1c0;
  // Timing steps
  localparam int unsigned SEG_DELAY_STEP_NS = 20;
  localparam int unsigned SOFT_OFF_BASE_NS = 2000;
  localparam int unsigned SOFT_OFF_STEP_NS = 1000;
  localparam int unsigned SC_FILTER_SLOW_BASE_NS = 400;
  localparam int unsigned SC_FILTER_FAST_BASE_NS = 100;
  localparam int unsigned SC_FILTER_STEP_NS = 100;
  // Soft-off current table, in milliamperes
  localparam logic [9:0] SOFT_OFF_MA [8] = '{10'h064, 10'h0c8, 10'h12c, 10'h190,
                                             10'h1f4, 10'h2bc, 10'h384, 10'h3e8};
  // Register field view
  typedef struct packed {
    logic failsafe_int_select;
    logic [2:0] segment_drive_delay;
    logic [2:0] soft_off_current;
    logic [2:0] soft_off_duration;
  } config_s;
  // Decoded timing outputs
  typedef struct packed {
    logic [15:0] seg_delay_ns;
    logic [15:0] soft_off_ns;
    logic [15:0] sc_filter_ns;
    logic [9:0] soft_off_ma;
  } timing_s;
endpackage
`default_nettype wire

/* core/timing_decode.sv */
// Decodes register codes into nanosecond and current figures.
// Assumes codes are stable register outputs; result is registered.
`default_nettype none
module timing_decode (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Codes
  input wire gate_cfg_pkg::config_s cfg,
  input wire logic time_scale_half,
  input wire logic [2:0] short_circuit_filter_time,
  input wire logic short_circuit_fast_filter,
  // Decoded values
  output gate_cfg_pkg::timing_s timing
);
  gate_cfg_pkg::timing_s timing_d; // Next decoded values
  gate_cfg_pkg::timing_s timing_q; // Registered decoded values
  logic [15:0] soft_full; // Unscaled soft-off duration

  // Combinational decode of every timing field
  always_comb begin
    soft_full = 16'(gate_cfg_pkg::SOFT_OFF_BASE_NS + gate_cfg_pkg::SOFT_OFF_STEP_NS * cfg.soft_off_duration);
    timing_d.seg_delay_ns = 16'(gate_cfg_pkg::SEG_DELAY_STEP_NS * cfg.segment_drive_delay);
    timing_d.soft_off_ma = gate_cfg_pkg::SOFT_OFF_MA[cfg.soft_off_current];
    if (time_scale_half) begin
      timing_d.soft_off_ns = {1'b0, soft_full[15:1]};
    end else begin
      timing_d.soft_off_ns = soft_full;
    end
    if (short_circuit_fast_filter) begin
      timing_d.sc_filter_ns = 16'(gate_cfg_pkg::SC_FILTER_FAST_BASE_NS
                                  + gate_cfg_pkg::SC_FILTER_STEP_NS * short_circuit_filter_time);
    end else begin
      timing_d.sc_filter_ns = 16'(gate_cfg_pkg::SC_FILTER_SLOW_BASE_NS
                                  + gate_cfg_pkg::SC_FILTER_STEP_NS * short_circuit_filter_time);
    end
  end

  // Register the decode
  always_ff @(posedge clock) begin
    if (reset) begin
      timing_q <= '0;
    end else begin
      timing_q <= timing_d;
    end
  end

  assign timing = timing_q;
endmodule
`default_nettype wire

/* core/soft_shutdown_delay_config.sv */
// Register 4 of the gate driver: storage, write lock, read-back, fail-safe pin.
// Assumes frames arrive already deserialised and CRC-checked by the SPI front end.
//
// Operation
// - Register 4 decoded from frame bits 22:18
// - Delay always writable, others locked in normal
// - Fail-safe select routes state to fault pin
// - With fail-safe select set, enable low drives fault pin low
// - Segment delay is code times 20 ns
// - Soft-off current decoded from eight-step table
// - Unscaled soft-off time 2000 plus 1000 steps
// - Scaling bit halves soft-off duration
// - Slow short-circuit filter 400 plus 100 steps
// - Fast short-circuit filter 100 plus 100 steps
// - Filter code kept when fast bit changes
// - Leaving configuration latches CRC, arms switching
`default_nettype none
module soft_shutdown_delay_config (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Received frame, one-cycle strobe at the frame end
  input wire logic frame_valid,
  input wire logic [23:0] frame_in,
  // Chip-select rising edge pulse, configuration mode level
  input wire logic chip_select_rise,
  input wire logic config_mode,
  // Neighbouring-register codes and mode bits
  input wire logic time_scale_half,
  input wire logic [2:0] short_circuit_filter_time,
  input wire logic short_circuit_fast_filter,
  // Fail-safe and PWM
  input wire logic failsafe_enable_input,
  input wire logic pwm_in,
  input wire logic fault_request,
  input wire logic [7:0] config_crc_in,
  // Outputs
  output logic fault_interrupt_pin,
  output logic [9:0] read_data,
  output logic read_valid,
  output logic [7:0] stored_crc,
  output logic switching_allowed,
  output gate_cfg_pkg::config_s cfg,
  output gate_cfg_pkg::timing_s timing
);
  logic [9:0] reg_d, reg_q; // Register contents
  logic [9:0] rd_d, rd_q; // Read-back data
  logic rv_d, rv_q; // Read-back strobe
  logic [7:0] crc_d, crc_q; // Stored configuration CRC
  logic cfg_d, cfg_q; // Configuration mode seen last cycle
  logic pend_d, pend_q; // Waiting for PWM rising edge after exit
  logic allow_d, allow_q; // Gate switching permitted
  logic pwm_d, pwm_q; // Previous PWM level
  logic int_d, int_q; // Fault pin level
  logic hit; // Frame targets register 4
  logic is_write; // Frame is a write
  logic [9:0] wmask; // Bits that accept the write
  logic exit_cfg; // Configuration left on this chip-select edge

  // Address decode on the frame fields
  assign hit = frame_valid
    && (frame_in[gate_cfg_pkg::ADDR_MSB:gate_cfg_pkg::ADDR_LSB]
        == gate_cfg_pkg::SOFT_SHUTDOWN_DELAY_CONFIG_ADDR);
  assign is_write = frame_in[gate_cfg_pkg::RW_POS];
  assign exit_cfg = chip_select_rise && cfg_q && !config_mode;

  // Next-state logic for storage, read-back, CRC and switching permission
  always_comb begin
    // Locked fields only accept writes in configuration mode
    wmask = config_mode ? 10'h3ff : gate_cfg_pkg::ALWAYS_WRITABLE_MASK;
    reg_d = reg_q;
    if (hit && is_write) begin
      reg_d = (reg_q & ~wmask)
        | (frame_in[gate_cfg_pkg::DATA_MSB:gate_cfg_pkg::DATA_LSB] & wmask);
    end
    rv_d = hit && !is_write;
    rd_d = rd_q;
    if (hit && !is_write) begin
      rd_d = reg_q;
    end
    cfg_d = config_mode;
    pwm_d = pwm_in;
    crc_d = crc_q;
    pend_d = pend_q;
    allow_d = allow_q;
    if (config_mode) begin
      // Gate held off while configuring
      allow_d = 1'b0;
      pend_d = 1'b0;
    end
    if (exit_cfg) begin
      crc_d = config_crc_in;
      pend_d = 1'b1;
    end else if (pend_q && !config_mode && pwm_in && !pwm_q) begin
      // A PWM edge seen while configuration is re-entered must not re-arm the gate
      allow_d = 1'b1;
      pend_d = 1'b0;
    end
    // Fault pin is active low; fail-safe select maps enable onto it
    if (reg_q[gate_cfg_pkg::FAILSAFE_INT_SELECT_POS]) begin
      int_d = failsafe_enable_input && !fault_request;
    end else begin
      int_d = !fault_request;
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_q <= gate_cfg_pkg::SOFT_SHUTDOWN_DELAY_CONFIG_RESET;
      rd_q <= '0;
      rv_q <= 1'b0;
      crc_q <= '0;
      cfg_q <= 1'b0;
      pend_q <= 1'b0;
      allow_q <= 1'b0;
      pwm_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
      crc_q <= crc_d;
      cfg_q <= cfg_d;
      pend_q <= pend_d;
      allow_q <= allow_d;
      pwm_q <= pwm_d;
      int_q <= int_d;
    end
  end

  // Field view and timing decode
  assign cfg = gate_cfg_pkg::config_s'(reg_q);
  timing_decode u_decode (
    .clock(clock),
    .reset(reset),
    .cfg(cfg),
    .time_scale_half(time_scale_half),
    .short_circuit_filter_time(short_circuit_filter_time),
    .short_circuit_fast_filter(short_circuit_fast_filter),
    .timing(timing)
  );

  assign read_data = rd_q;
  assign read_valid = rv_q;
  assign stored_crc = crc_q;
  assign switching_allowed = allow_q;
  assign fault_interrupt_pin = int_q;
endmodule
`default_nettype wire

/* sim/host_model.sv */
// Host model: issues one 24-bit frame to the register block per call.
// Assumes the caller sits just after a rising clock edge.
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Frame strobe and word
  output logic frame_valid = 1'h0,
  output logic [23:0] frame_in = 24'h000000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Frame held for one taken edge, then scrambled so stale bits never look valid
  task automatic xfer(input logic rw, input logic [4:0] addr, input logic [9:0] data);
    @(posedge clock);
    frame_valid <= 1'h1;
    frame_in <= {rw, addr, data, 8'h00};
    @(posedge clock);
    frame_valid <= 1'h0;
    frame_in <= ~frame_in;
  endtask
endmodule
`default_nettype wire

/* sim/gate_cfg_properties.sv */
// Checker for the register 4 block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module gate_cfg_properties (
  // Clock, reset and inputs
  input wire logic clock,
  input wire logic reset,
  input wire logic frame_valid,
  input wire logic [23:0] frame_in,
  input wire logic chip_select_rise,
  input wire logic config_mode,
  input wire logic time_scale_half,
  input wire logic [2:0] short_circuit_filter_time,
  input wire logic short_circuit_fast_filter,
  input wire logic failsafe_enable_input,
  input wire logic fault_request,
  input wire logic [7:0] config_crc_in,
  // Outputs
  input wire logic fault_interrupt_pin,
  input wire logic [9:0] read_data,
  input wire logic read_valid,
  input wire logic [7:0] stored_crc,
  input wire logic switching_allowed,
  input wire gate_cfg_pkg::config_s cfg,
  input wire gate_cfg_pkg::timing_s timing
);
  timeunit 1ns;
  timeprecision 1ps;
  // Frames aimed at register 4
  wire logic w4 = frame_valid && frame_in[23] && frame_in[22:18] == 5'h04;
  wire logic r4 = frame_valid && !frame_in[23] && frame_in[22:18] == 5'h04;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_cfg_write: assert property (w4 && config_mode |=> cfg == $past(frame_in[17:8])) else $error("write lost");
  a_normal_lock: assert property (w4 && !config_mode |=>
    cfg == {$past(cfg[9]), $past(frame_in[16:14]), $past(cfg[5:0])}) else $error("lock broken");
  a_read_back: assert property (r4 |=> read_valid && read_data == $past(cfg)) else $error("bad read");
  a_fault_pin: assert property (!$past(reset) |-> fault_interrupt_pin ==
    ($past(cfg[9]) ? $past(failsafe_enable_input) && !$past(fault_request) : !$past(fault_request))) else $error("bad pin");
  a_seg_delay: assert property (!$past(reset) |->
    timing.seg_delay_ns == 16'($past(cfg[8:6])) * 16'h0014) else $error("bad delay");
  a_soft_off_time: assert property (!$past(reset) |-> timing.soft_off_ns == ($past(time_scale_half) ?
    16'h03e8 + 16'($past(cfg[2:0])) * 16'h01f4 : 16'h07d0 + 16'($past(cfg[2:0])) * 16'h03e8)) else $error("bad time");
  a_sc_filter: assert property (!$past(reset) |-> timing.sc_filter_ns ==
    ($past(short_circuit_fast_filter) ? 16'h0064 : 16'h0190) + 16'($past(short_circuit_filter_time)) * 16'h0064)
    else $error("bad filter");
  a_crc_latch: assert property (chip_select_rise && !config_mode && $past(config_mode) |=>
    stored_crc == $past(config_crc_in)) else $error("crc not kept");
  a_gate_held: assert property (config_mode |=> !switching_allowed) else $error("gate armed in config");
  c_read: cover property (r4);
  c_lock: cover property (w4 && !config_mode);
  c_exit: cover property (chip_select_rise && !config_mode && $past(config_mode));
endmodule
bind soft_shutdown_delay_config gate_cfg_properties gate_cfg_properties_inst (
  .clock(clock),
  .reset(reset),
  .frame_valid(frame_valid),
  .frame_in(frame_in),
  .chip_select_rise(chip_select_rise),
  .config_mode(config_mode),
  .time_scale_half(time_scale_half),
  .short_circuit_filter_time(short_circuit_filter_time),
  .short_circuit_fast_filter(short_circuit_fast_filter),
  .failsafe_enable_input(failsafe_enable_input),
  .fault_request(fault_request),
  .config_crc_in(config_crc_in),
  .fault_interrupt_pin(fault_interrupt_pin),
  .read_data(read_data),
  .read_valid(read_valid),
  .stored_crc(stored_crc),
  .switching_allowed(switching_allowed),
  .cfg(cfg),
  .timing(timing)
);
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the register 4 block.
// Assumes the host model issues frames and the checker is bound in.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Driven inputs, design outputs, expected notes
  logic clock = 1'h0, reset = 1'h1, config_mode = 1'h0, chip_select_rise = 1'h0, time_scale_half = 1'h0;
  logic short_circuit_fast_filter = 1'h0, failsafe_enable_input = 1'h1, pwm_in = 1'h0, fault_request = 1'h0;
  logic [2:0] short_circuit_filter_time = 3'h0;
  logic [7:0] config_crc_in = 8'h00, stored_crc;
  logic frame_valid, fault_interrupt_pin, read_valid, switching_allowed;
  logic [23:0] frame_in;
  logic [9:0] read_data, m, q[$];
  logic [9:0] ma [8] = '{10'h064, 10'h0c8, 10'h12c, 10'h190, 10'h1f4, 10'h2bc, 10'h384, 10'h3e8};
  gate_cfg_pkg::config_s cfg;
  gate_cfg_pkg::timing_s timing;
  int err_count = 0, checks = 0;
  always #20 clock = ~clock;
  host_model host_model_inst (.clock(clock), .frame_valid(frame_valid), .frame_in(frame_in));
  soft_shutdown_delay_config soft_shutdown_delay_config_inst (
    .clock(clock),
    .reset(reset),
    .frame_valid(frame_valid),
    .frame_in(frame_in),
    .chip_select_rise(chip_select_rise),
    .config_mode(config_mode),
    .time_scale_half(time_scale_half),
    .short_circuit_filter_time(short_circuit_filter_time),
    .short_circuit_fast_filter(short_circuit_fast_filter),
    .failsafe_enable_input(failsafe_enable_input),
    .pwm_in(pwm_in),
    .fault_request(fault_request),
    .config_crc_in(config_crc_in),
    .fault_interrupt_pin(fault_interrupt_pin),
    .read_data(read_data),
    .read_valid(read_valid),
    .stored_crc(stored_crc),
    .switching_allowed(switching_allowed),
    .cfg(cfg),
    .timing(timing)
  );
  // Random side levels every cycle
  always @(posedge clock)
    {time_scale_half, short_circuit_filter_time, short_circuit_fast_filter, failsafe_enable_input, pwm_in,
      fault_request, config_crc_in} <= 16'($urandom);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    err_count += int'(got !== exp);
  endtask
  // Read of register 4, expectation noted first
  task rd;
    q.push_back(m);
    host_model_inst.xfer(1'h0, 5'h04, 10'h000);
  endtask
  // Each read answer against the oldest note
  always @(posedge clock) if (read_valid === 1'h1) chk(16'(read_data), 16'(q.pop_front()));
  task results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7e16ec33));
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    m = 10'h024;
    rd();
    $display("reset test done");
    // Every current code, then a locked write of inverted bits
    for (int i = 0; i < 8; i++) begin
      config_mode <= 1'h1;
      m = 10'($urandom);
      m[5:3] = 3'(i);
      host_model_inst.xfer(1'h1, 5'h04, m);
      repeat (2) @(posedge clock);
      chk(16'(timing.soft_off_ma), 16'(ma[i]));
      config_mode <= 1'h0;
      host_model_inst.xfer(1'h1, 5'h04, ~m);
      m[8:6] = ~m[8:6];
      rd();
    end
    $display("write lock test done");
    // Unmapped write ignored, then leave configuration
    config_mode <= 1'h1;
    host_model_inst.xfer(1'h1, 5'h05, ~m);
    rd();
    config_mode <= 1'h0;
    chip_select_rise <= 1'h1;
    @(posedge clock);
    chip_select_rise <= 1'h0;
    for (int i = 0; i < 50 && switching_allowed !== 1'h1; i++) @(posedge clock);
    chk(16'(switching_allowed), 16'h0001);
    $display("exit test done");
    repeat (3) @(posedge clock);
    // Every noted read must have been answered
    chk(16'(q.size()), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
